/* rtl/isp_top.sv */
/*
  Pin-level logic of a 12-bit image sensor: colour layout of the array,
  serial or parallel output mode, parallel pixel bus with its own pixel
  clock, general inputs, flash and shutter outputs, and a serial register
  port clocked by the host.
  Assumes clk is the master clock, reg_serial_clock is driven by the host
  and stands still between frames, and the pins are sampled here.
*/
// Contract
// R1: even rows green/red, odd rows blue/green
// R2: even columns green/blue, odd columns red/green
// R3: serial output enabled after power-up
// R4: serial or parallel output, one selected
// R5: power-off stops output, restores defaults; code stops the parallel bus only, serial_lane_enable stays 1
// R6: general inputs powered down after reset
// R7: inputs control standby, enable, address, trigger
// R8: 12-bit data bus qualified by pixel clock
// R9: line and frame markers on same clock
// R10: flash output gives exposure sync pulse
// R11: shutter output drives external mechanical shutter
// R12: registers via host clock and two-way data
// R13: host supplies master clock 6 to 48 MHz; ISP_CLK_NS assumes an 8 ns clk (125 MHz)
// R14: board ties test input, never floating
// R15: each pixel a 12-bit word with markers
// R16: pixel clock never above 80 MHz
`timescale 1ns/1ps
`include "isp_consts.svh"

module isp_top (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          reg_serial_clock,
  input  wire logic          power_off_n,
  input  wire logic          reg_serial_data_in,
  output isp_pkg::isp_pin_s  reg_serial_data,
  input  wire logic [3:0]    general_inputs,
  output isp_pkg::isp_pix_s  pixel_bus,
  output logic               flash_sync,
  output logic               shutter_ctrl,
  output logic               serial_lane_enable
);
  import isp_pkg::*;

  isp_core_s ps_q, ps_d;
  isp_link_s ls_q, ls_d;
  logic      lr_m, lr_s;

  localparam isp_core_s PS_RST = '{
    pwr_m: 1'b0, pwr_s: 1'b0, gpi_m: 4'h0, gpi_s: 4'h0, wt: 3'h0,
    ak: 2'h0, rst_link: 1'b1, ctrl: `ISP_CTRL_RST,
    gpi_en: `ISP_GPI_EN_RST, gpi_fn: `ISP_GPI_FN_RST, asel: 1'b0,
    mreq: 1'b0, mirror: 32'h0, st: P_VBLANK, half: 4'h0, pclk: 1'b0,
    col: 5'h00, row: 4'h0, blank: 4'h0, frames: 8'h00, trig_prev: 1'b0,
    flash_cnt: 4'h0, flash: 1'b0, shutter: 1'b0, ser_en: 1'b1,
    pix: '0};

  localparam isp_link_s LS_RST = '{
    as_m: 1'b0, as_s: 1'b0, rq_m: 1'b0, rq_s: 1'b0, ack: 1'b0,
    shadow: 32'h0, st: L_IDLE, cnt: 4'h0, hdr: 5'h00, match: 1'b0,
    addr: 3'h0, sh: 8'h00, wr_addr: `ISP_REG_STATUS, wr_data: 8'h00,
    wr_tgl: 1'b0, pin: '0};

  // colour of a pixel from row and column parity
  function automatic logic [1:0] bayer(input logic row0, input logic col0);
    if (!row0)
      bayer = col0 ? COL_RED : COL_GREEN;   // R1
    else
      bayer = col0 ? COL_GREEN : COL_BLUE;  // R2
  endfunction : bayer

  // an enabled general input set to a function and driven high
  function automatic logic gpi_hit(input logic [3:0] en,
                                   input logic [7:0] fn,
                                   input logic [3:0] val,
                                   input isp_gpi_fn_e sel);
    gpi_hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (en[i] && fn[2*i +: 2] == sel && val[i])
        gpi_hit = 1'b1;
    end
  endfunction : gpi_hit

  // byte of the register mirror picked by a register index
  function automatic logic [7:0] reg_byte(input logic [31:0] m,
                                          input logic [2:0]  a);
    case (a)
      `ISP_REG_CTRL:   reg_byte = m[31:24];
      `ISP_REG_GPI_EN: reg_byte = m[23:16];
      `ISP_REG_GPI_FN: reg_byte = m[15:8];
      `ISP_REG_STATUS: reg_byte = m[7:0];
      default:         reg_byte = 8'h00;
    endcase
  endfunction : reg_byte

  // core domain: registers, pixel timing, flash and shutter
  always_comb begin
    logic tick;
    logic par_on;
    logic stby;
    logic oe_off;
    logic trig;
    // disabled pads read as low, so a floating pad does nothing
    stby = gpi_hit(ps_q.gpi_en, ps_q.gpi_fn, ps_q.gpi_s, GPI_STANDBY); // R6 R7
    oe_off = gpi_hit(ps_q.gpi_en, ps_q.gpi_fn, ps_q.gpi_s, GPI_OE_N);
    trig = gpi_hit(ps_q.gpi_en, ps_q.gpi_fn, ps_q.gpi_s, GPI_TRIGGER);
    par_on = ps_q.ctrl[`ISP_CTRL_PAR_BIT] && !stby;
    tick = 1'b0;
    ps_d = ps_q;
    ps_d.pwr_m = power_off_n;
    ps_d.pwr_s = ps_q.pwr_m;
    ps_d.gpi_m = general_inputs;
    ps_d.gpi_s = ps_q.gpi_m;
    ps_d.wt = {ps_q.wt[1:0], ls_q.wr_tgl};
    ps_d.ak = {ps_q.ak[0], ls_q.ack};
    ps_d.rst_link = 1'b0;
    ps_d.asel = gpi_hit(ps_q.gpi_en, ps_q.gpi_fn, ps_q.gpi_s, GPI_ADDR_SEL);
    // write word is held still by the link until its toggle is seen
    if (ps_q.wt[2] ^ ps_q.wt[1]) begin                                 // R12
      case (ls_q.wr_addr)
        `ISP_REG_CTRL:   ps_d.ctrl = ls_q.wr_data;
        `ISP_REG_GPI_EN: ps_d.gpi_en = ls_q.wr_data[3:0];
        `ISP_REG_GPI_FN: ps_d.gpi_fn = ls_q.wr_data;
        default:         ps_d.ctrl = ps_q.ctrl;
      endcase
    end
    // republish the mirror only after the last copy was taken
    if (ps_q.mreq == ps_q.ak[1]) begin
      ps_d.mirror = {ps_q.ctrl, 4'h0, ps_q.gpi_en, ps_q.gpi_fn,
                     ps_q.frames};
      ps_d.mreq = ~ps_q.mreq;
    end
    ps_d.ser_en = !ps_q.ctrl[`ISP_CTRL_PAR_BIT] && !stby;              // R4
    // pixel clock divider; a pixel step happens on its falling edge
    if (ps_q.half == 4'(`ISP_PCLK_HALF - 1)) begin                     // R16
      ps_d.half = 4'h0;
      ps_d.pclk = ~ps_q.pclk;
      tick = ps_q.pclk;
    end else begin
      ps_d.half = ps_q.half + 4'h1;
    end
    // trigger edge opens the shutter until the next frame starts
    ps_d.trig_prev = trig;
    if (trig && !ps_q.trig_prev && ps_q.ctrl[`ISP_CTRL_SHUT_BIT])
      ps_d.shutter = 1'b1;                                             // R11
    if (ps_q.flash_cnt != 4'h0)
      ps_d.flash_cnt = ps_q.flash_cnt - 4'h1;
    ps_d.flash = ps_q.flash_cnt != 4'h0;
    if (tick) begin
      case (ps_q.st)
        P_VBLANK: begin
          ps_d.pix.line = 1'b0;
          ps_d.pix.frame = 1'b0;
          ps_d.blank = ps_q.blank + 4'h1;
          if (ps_q.blank == `ISP_VBLANK - 4'h1) begin
            ps_d.st = P_LINE;
            ps_d.row = 4'h0;
            ps_d.col = 5'h00;
            ps_d.pix.frame = 1'b1;                                     // R9
            ps_d.frames = ps_q.frames + 8'h01;
            ps_d.shutter = 1'b0;                                       // R11
            if (ps_q.ctrl[`ISP_CTRL_FLASH_BIT])
              ps_d.flash_cnt = 4'(`ISP_FLASH_CYC);                     // R10
          end
        end
        P_LINE: begin
          // word: colour, frame count, row, column
          ps_d.pix.data = {bayer(ps_q.row[0], ps_q.col[0]),
                           ps_q.frames[1:0], ps_q.row,
                           ps_q.col[3:0]};                             // R15
          ps_d.pix.line = 1'b1;                                        // R9
          ps_d.col = ps_q.col + 5'h01;
          if (ps_q.col == `ISP_LINE_PIX - 5'h01) begin
            ps_d.st = P_HBLANK;
            ps_d.blank = 4'h0;
          end
        end
        P_HBLANK: begin
          ps_d.pix.line = 1'b0;
          ps_d.pix.data = 12'h000;
          ps_d.blank = ps_q.blank + 4'h1;
          if (ps_q.blank == `ISP_HBLANK - 4'h1) begin
            ps_d.blank = 4'h0;
            ps_d.col = 5'h00;
            if (ps_q.row == `ISP_ROWS - 4'h1) begin
              ps_d.st = P_VBLANK;
            end else begin
              ps_d.row = ps_q.row + 4'h1;
              ps_d.st = P_LINE;
            end
          end
        end
        default: ps_d.st = P_VBLANK;
      endcase
    end
    // standby holds the array between frames
    if (stby) begin
      ps_d.st = P_VBLANK;
      ps_d.blank = 4'h0;
      ps_d.pix.line = 1'b0;
      ps_d.pix.frame = 1'b0;
      ps_d.pix.data = 12'h000;
    end
    // parallel pins rest low unless parallel mode and enabled
    ps_d.pix.clock = ps_d.pclk && par_on && !oe_off;                   // R8
    if (!par_on || oe_off) begin
      ps_d.pix.data = 12'h000;
      ps_d.pix.line = 1'b0;
      ps_d.pix.frame = 1'b0;
    end
    // power-off pin: defaults everywhere except mreq, which is kept; power, write and ack synchronisers keep running
    if (!ps_q.pwr_s) begin                                             // R5
      ps_d = PS_RST;
      ps_d.pwr_m = power_off_n;
      ps_d.pwr_s = ps_q.pwr_m;
      ps_d.wt = {ps_q.wt[1:0], ls_q.wr_tgl};
      ps_d.ak = {ps_q.ak[0], ls_q.ack};
      ps_d.mreq = ps_q.mreq;
    end
  end

  always_ff @(posedge clk) begin
    if (reset)
      ps_q <= PS_RST;                                                  // R3
    else
      ps_q <= ps_d;
  end

  // link reset: raised at once, released on the host clock
  always_ff @(posedge reg_serial_clock or posedge ps_q.rst_link) begin
    if (ps_q.rst_link) begin
      lr_m <= 1'b1;
      lr_s <= 1'b1;
    end else begin
      lr_m <= 1'b0;
      lr_s <= lr_m;
    end
  end

  // link domain: start bit, id, read/write, address, one data byte
  always_comb begin
    logic [4:0] hdr;
    hdr = {ls_q.hdr[3:0], reg_serial_data_in};
    ls_d = ls_q;
    ls_d.as_m = ps_q.asel;
    ls_d.as_s = ls_q.as_m;
    ls_d.rq_m = ps_q.mreq;
    ls_d.rq_s = ls_q.rq_m;
    if (ls_q.rq_s != ls_q.ack) begin
      ls_d.shadow = ps_q.mirror;
      ls_d.ack = ls_q.rq_s;
    end
    ls_d.cnt = ls_q.cnt + 4'h1;
    case (ls_q.st)
      L_IDLE: begin
        ls_d.pin = '0;
        ls_d.cnt = 4'h0;
        if (!reg_serial_data_in)
          ls_d.st = L_HDR;
      end
      L_HDR: begin
        ls_d.hdr = hdr;
        if (ls_q.cnt == `ISP_HDR_LAST) begin
          ls_d.cnt = 4'h0;
          ls_d.match = hdr[4] == ls_q.as_s;                            // R7
          ls_d.addr = hdr[2:0];
          ls_d.st = hdr[3] ? L_RD : L_WR;
          ls_d.sh = reg_byte(ls_q.shadow, hdr[2:0]);
          ls_d.pin.o = ls_d.sh[7];
          ls_d.pin.oe = hdr[3] && hdr[4] == ls_q.as_s;                 // R12
        end
      end
      L_WR: begin
        ls_d.sh = {ls_q.sh[6:0], reg_serial_data_in};
        if (ls_q.cnt == `ISP_BYTE_LAST) begin
          ls_d.st = L_IDLE;
          if (ls_q.match) begin                                        // R12
            ls_d.wr_addr = ls_q.addr;
            ls_d.wr_data = ls_d.sh;
            ls_d.wr_tgl = ~ls_q.wr_tgl;
          end
        end
      end
      L_RD: begin
        ls_d.sh = {ls_q.sh[6:0], 1'b0};
        ls_d.pin.o = ls_q.sh[6];
        if (ls_q.cnt == `ISP_BYTE_LAST) begin
          ls_d.pin = '0;
          ls_d.st = L_IDLE;
        end
      end
      default: ls_d.st = L_IDLE;
    endcase
  end

  // reset parks the write word on a read-only index, so a toggle step
  // seen by the core during reset writes nothing
  always_ff @(posedge reg_serial_clock or posedge lr_s) begin
    if (lr_s)
      ls_q <= LS_RST;
    else
      ls_q <= ls_d;
  end

  assign pixel_bus          = ps_q.pix;
  assign flash_sync         = ps_q.flash;
  assign shutter_ctrl       = ps_q.shutter;
  assign serial_lane_enable = ps_q.ser_en;
  assign reg_serial_data    = ls_q.pin;

  AST_BAYER: assert property (@(posedge clk) disable iff (reset) // R1
    ps_q.pix.line |-> ps_q.pix.data[11:10] ==
      bayer(ps_q.pix.data[4], ps_q.pix.data[0]))
    else $error("pixel colour does not match row and column parity");
  AST_COLUMNS: assert property (@(posedge clk) disable iff (reset) // R2
    ps_q.pix.line && ps_q.pix.data[0] |-> ps_q.pix.data[11:10] != COL_BLUE)
    else $error("odd column carries blue");
  AST_SERIAL_DEFAULT: assert property (@(posedge clk) // R3
    $fell(reset) |-> ps_q.ser_en && !ps_q.pix.clock)
    else $error("serial output not enabled after reset");
  AST_ONE_MODE: assert property (@(posedge clk) disable iff (reset) // R4
    ps_q.ser_en |-> !ps_q.pix.clock && !ps_q.pix.frame)
    else $error("parallel bus active in serial mode");
  AST_POWER_OFF: assert property (@(posedge clk) disable iff (reset) // R5
    !ps_q.pwr_s |=> ps_q.pix == '0 && ps_q.ctrl == `ISP_CTRL_RST)
    else $error("power-off did not stop output");
  AST_GPI_DOWN: assert property (@(posedge clk) // R6
    $past(reset) || !ps_q.pwr_s |=> ps_q.gpi_en == 4'h0)
    else $error("general inputs not powered down after reset");
  AST_QUALIFIED: assert property (@(posedge clk) disable iff (reset) // R8
    !$stable({ps_q.pix.data, ps_q.pix.line}) |-> !ps_q.pix.clock)
    else $error("pixel data changed while pixel clock high");
  AST_FRAME_EDGE: assert property (@(posedge clk) disable iff (reset) // R9
    $rose(ps_q.pix.frame) |-> !ps_q.pix.clock ##1 ps_q.pix.clock)
    else $error("frame marker not aligned to pixel clock");
  AST_FLASH_WIDTH: assert property (@(posedge clk) disable iff (reset) // R10
    $rose(ps_q.flash) |-> ps_q.flash [*8] ##1 ps_q.flash [*5] ##1 !ps_q.flash)
    else $error("flash pulse width wrong");
  AST_SHUTTER_CLOSE: assert property (@(posedge clk) disable iff (reset) // R11
    $rose(ps_q.pix.frame) |-> !ps_q.shutter)
    else $error("shutter still open at frame start");
  AST_READ_DRIVE: assert property (@(posedge reg_serial_clock)
    disable iff (lr_s) // R12
    $rose(ls_q.pin.oe) |-> ls_q.pin.oe [*8] ##1 !ls_q.pin.oe)
    else $error("read data not driven for exactly eight bits");
  AST_PCLK_RATE: assert property (@(posedge clk) disable iff (reset) // R16
    $rose(ps_q.pix.clock) |=> !ps_q.pix.clock)
    else $error("pixel clock high longer than one core cycle");

endmodule : isp_top

/* shared/isp_consts.svh */
/*
  Constants of the image sensor pin block: register indices on the serial
  register port, field positions, reset values and timing counts.
  Assumes the core clock runs with the period given by ISP_CLK_NS.
*/
`ifndef ISP_CONSTS_SVH
`define ISP_CONSTS_SVH

// register indices on the serial register port
`define ISP_REG_CTRL       3'h0
`define ISP_REG_GPI_EN     3'h1
`define ISP_REG_GPI_FN     3'h2
`define ISP_REG_STATUS     3'h3

// control register fields and reset values
`define ISP_CTRL_PAR_BIT   0
`define ISP_CTRL_FLASH_BIT 1
`define ISP_CTRL_SHUT_BIT  2
`define ISP_CTRL_RST       8'h00
`define ISP_GPI_EN_RST     4'h0
`define ISP_GPI_FN_RST     8'h00

// serial frame: start bit, id, read/write, three address bits, one byte
`define ISP_HDR_LAST       4'h4
`define ISP_BYTE_LAST      4'h7

// frame geometry, in pixel clock periods
`define ISP_LINE_PIX       5'h10
`define ISP_ROWS           4'h8
`define ISP_HBLANK         4'h4
`define ISP_VBLANK         4'h6

// timing: core clock, pixel clock ceiling, flash pulse width
`define ISP_CLK_NS         8
`define ISP_PCLK_MAX_MHZ   80
`define ISP_FLASH_NS       104
`define ISP_PCLK_HALF \
  ((1000 + 2 * `ISP_CLK_NS * `ISP_PCLK_MAX_MHZ - 1) / \
   (2 * `ISP_CLK_NS * `ISP_PCLK_MAX_MHZ))
`define ISP_FLASH_CYC \
  ((`ISP_FLASH_NS + `ISP_CLK_NS - 1) / `ISP_CLK_NS)

`endif

/* shared/isp_pkg.sv */
/*
  Types of the image sensor pin block: modes, states, pin carriers and the
  state records of both clock domains.
  Assumes isp_consts.svh for all numeric values.
*/
package isp_pkg;

  typedef enum logic [1:0] {
    GPI_STANDBY  = 2'b00,
    GPI_OE_N     = 2'b01,
    GPI_ADDR_SEL = 2'b10,
    GPI_TRIGGER  = 2'b11
  } isp_gpi_fn_e;

  typedef enum logic [1:0] {
    COL_GREEN = 2'b00,
    COL_RED   = 2'b01,
    COL_BLUE  = 2'b10
  } isp_colour_e;

  typedef enum logic [1:0] {
    P_VBLANK = 2'b00,
    P_LINE   = 2'b01,
    P_HBLANK = 2'b10
  } isp_pix_st_e;

  typedef enum logic [1:0] {
    L_IDLE = 2'b00,
    L_HDR  = 2'b01,
    L_WR   = 2'b10,
    L_RD   = 2'b11
  } isp_link_st_e;

  typedef struct packed {
    logic [11:0] data;
    logic        line;
    logic        frame;
    logic        clock;
  } isp_pix_s;

  typedef struct packed {
    logic o;
    logic oe;
  } isp_pin_s;

  typedef struct packed {
    logic        pwr_m;
    logic        pwr_s;
    logic [3:0]  gpi_m;
    logic [3:0]  gpi_s;
    logic [2:0]  wt;
    logic [1:0]  ak;
    logic        rst_link;
    logic [7:0]  ctrl;
    logic [3:0]  gpi_en;
    logic [7:0]  gpi_fn;
    logic        asel;
    logic        mreq;
    logic [31:0] mirror;
    isp_pix_st_e st;
    logic [3:0]  half;
    logic        pclk;
    logic [4:0]  col;
    logic [3:0]  row;
    logic [3:0]  blank;
    logic [7:0]  frames;
    logic        trig_prev;
    logic [3:0]  flash_cnt;
    logic        flash;
    logic        shutter;
    logic        ser_en;
    isp_pix_s    pix;
  } isp_core_s;

  typedef struct packed {
    logic         as_m;
    logic         as_s;
    logic         rq_m;
    logic         rq_s;
    logic         ack;
    logic [31:0]  shadow;
    isp_link_st_e st;
    logic [3:0]   cnt;
    logic [4:0]   hdr;
    logic         match;
    logic [2:0]   addr;
    logic [7:0]   sh;
    logic [2:0]   wr_addr;
    logic [7:0]   wr_data;
    logic         wr_tgl;
    isp_pin_s     pin;
  } isp_link_s;

endpackage : isp_pkg

/* verif/isp_host.sv */
/*
  Host model of the serial register port: clocks frames, drives or
  releases the data line, samples read bits.
  Assumes the bench resolves the data line with a pull-up.
*/
`timescale 1ns/1ps

module isp_host (
  output logic      sclk,
  output logic      line_val,
  output logic      line_drv,
  input  wire logic line_seen
);
  // clock stands still between frames, as a real host leaves it
  initial begin
    sclk     = 1'b0;
    line_val = 1'b1;
    line_drv = 1'b0;
  end

  // one 48 ns period; sampling before the rise sees the last device bit
  task automatic tick(input logic b, input logic d, output logic s);
    line_val = b;
    line_drv = d;
    #24;
    s    = line_seen;
    sclk = 1'b1;
    #24;
    sclk = 1'b0;
  endtask : tick

  // idle periods, line released; odd offset keeps phase unrelated
  task automatic idle(input int n);
    logic s;
    #3.3;
    repeat (n) tick(1'b1, 1'b0, s);
  endtask : idle

  // start, id, rw, address, byte; host lets go during read data
  task automatic xfer(input logic id, input logic rw, input logic [2:0] a,
                      input logic [7:0] wd, output logic [7:0] rd);
    logic [13:0] f;
    logic        s;
    #3.3;
    f = {1'b0, id, rw, a, wd};
    for (int i = 13; i >= 0; i--) begin
      tick(f[i], !(rw && i < 8), s);
      if (i < 8) rd[i] = s;
    end
    tick(1'b1, 1'b0, s);
  endtask : xfer
endmodule : isp_host

/* verif/tb_top.sv */
/*
  Self-checking bench of the sensor pin block: register port through the
  host model, pixel stream capture, general inputs, flash and shutter.
  Assumes isp_top as declared and a pull-up on the serial data line.
*/
`timescale 1ns/1ps
`include "isp_consts.svh"

module tb_top;
  import isp_pkg::*;
  logic     clk;
  logic     reset;
  logic     power_off_n;
  logic     [3:0] general_inputs;
  logic     sclk;
  logic     h_val;
  logic     h_drv;
  logic     line_seen;
  logic     id_lvl;
  isp_pin_s sd;
  isp_pix_s pix;
  logic     flash_sync;
  logic     shutter_ctrl;
  logic     serial_lane_enable;
  int       err_count;
  int       compares;

  // master clock stand-in, 8 ns
  initial clk = 1'b0;
  always #4 clk = ~clk;

  // wire level: device, else host, else pull-up
  assign line_seen = sd.oe ? sd.o : (h_drv ? h_val : 1'b1);

  isp_top DUT (
    .clk                (clk),
    .reset              (reset),
    .reg_serial_clock   (sclk),
    .power_off_n        (power_off_n),
    .reg_serial_data_in (line_seen),
    .reg_serial_data    (sd),
    .general_inputs     (general_inputs),
    .pixel_bus          (pix),
    .flash_sync         (flash_sync),
    .shutter_ctrl       (shutter_ctrl),
    .serial_lane_enable (serial_lane_enable)
  );

  isp_host HOST (
    .sclk      (sclk),
    .line_val  (h_val),
    .line_drv  (h_drv),
    .line_seen (line_seen)
  );

  // verdict and end of run
  task automatic test_done();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // a limit ran out: count it and stop
  task automatic fail_out();
    err_count++;
    test_done();
  endtask : fail_out

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  // writes settle in the core a few clocks after the last bit
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] v;
    HOST.xfer(id_lvl, 1'b0, a, d, v);
    repeat (6) step();
  endtask : wr

  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    HOST.xfer(id_lvl, 1'b1, a, 8'h00, v);
    chk({8'h00, v}, {8'h00, e});
  endtask : rdc

  // next rising pixel clock; k counts core cycles since the call
  task automatic pix_rise(output int k);
    logic p;
    k = 0;
    do begin
      p = pix.clock;
      step();
      k++;
      if (k > 8) fail_out();
    end while (!(p === 1'b0 && pix.clock === 1'b1));
  endtask : pix_rise

  task automatic frame_start();
    int n;
    for (n = 0; pix.frame !== 1'b0; n++) begin
      step();
      if (n > 2000) fail_out();
    end
    for (n = 0; pix.frame !== 1'b1; n++) begin
      step();
      if (n > 2000) fail_out();
    end
  endtask : frame_start

  task automatic t_reset();
    chk({15'h0, serial_lane_enable}, 16'h1);
    chk({1'b0, pix}, 16'h0);
    chk({14'h0, flash_sync, shutter_ctrl}, 16'h0);
    rdc(`ISP_REG_CTRL, 8'h00);
    rdc(`ISP_REG_GPI_EN, 8'h00);
    rdc(`ISP_REG_GPI_FN, 8'h00);
    wr(3'h5, 8'hff);
    rdc(3'h5, 8'h00);
  endtask : t_reset

  // one whole frame: geometry, colour layout, pixel clock period
  task automatic t_frame();
    int r, c, k, n;
    logic [1:0] ec;
    r = 0;
    c = 0;
    wr(`ISP_REG_CTRL, 8'h01);
    rdc(`ISP_REG_CTRL, 8'h01);
    chk({15'h0, serial_lane_enable}, 16'h0);
    frame_start();
    pix_rise(k);
    for (n = 0; pix.frame === 1'b1 && n < 400; n++) begin
      if (pix.line === 1'b1) begin
        ec = r[0] ? (c[0] ? COL_GREEN : COL_BLUE)
                  : (c[0] ? COL_RED : COL_GREEN);
        chk({pix.data[11:10], pix.data[7:0]}, {ec, r[3:0], c[3:0]});
        c++;
        if (c == 16) begin
          c = 0;
          r++;
        end
      end
      pix_rise(k);
      chk(16'(k), 16'h2);
    end
    chk(16'(r), 16'h8);
    chk(16'(c), 16'h0);
  endtask : t_frame

  task automatic t_flash();
    int n;
    wr(`ISP_REG_CTRL, 8'h03);
    frame_start();
    for (n = 0; flash_sync !== 1'b1 && n < 4; n++) step();
    for (n = 0; flash_sync === 1'b1 && n < 40; n++) step();
    chk(16'(n), 16'(`ISP_FLASH_CYC));
  endtask : t_flash

  // gpi0 trigger, gpi1 standby, gpi2 address select, gpi3 output enable
  task automatic t_gpi();
    wr(`ISP_REG_GPI_FN, 8'h63);
    wr(`ISP_REG_GPI_EN, 8'h0f);
    wr(`ISP_REG_CTRL, 8'h05);
    // trigger just after a frame start, so no frame closes it too soon
    frame_start();
    general_inputs[0] = 1'b1;
    repeat (10) step();
    chk({15'h0, shutter_ctrl}, 16'h1);
    frame_start();
    repeat (3) step();
    chk({15'h0, shutter_ctrl}, 16'h0);
    general_inputs = 4'h2;
    repeat (10) step();
    chk({15'h0, serial_lane_enable}, 16'h0);
    repeat (40) begin
      step();
      chk({14'h0, pix.frame, pix.line}, 16'h0);
    end
    general_inputs = 4'h8;
    repeat (10) step();
    repeat (20) begin
      step();
      chk({1'b0, pix}, 16'h0);
    end
    general_inputs = 4'h4;
    repeat (10) step();
    rdc(`ISP_REG_CTRL, 8'hff);
    id_lvl = 1'b1;
    rdc(`ISP_REG_CTRL, 8'h05);
    general_inputs = 4'h0;
    id_lvl = 1'b0;
    repeat (10) step();
  endtask : t_gpi

  task automatic t_power();
    power_off_n = 1'b0;
    repeat (6) step();
    chk({15'h0, serial_lane_enable}, 16'h1);
    chk({1'b0, pix}, 16'h0);
    chk({15'h0, shutter_ctrl}, 16'h0);
    power_off_n = 1'b1;
    repeat (6) step();
    HOST.idle(3);
    rdc(`ISP_REG_CTRL, 8'h00);
    rdc(`ISP_REG_GPI_EN, 8'h00);
    rdc(`ISP_REG_GPI_FN, 8'h00);
  endtask : t_power

  // reset held six cycles, then each scenario in turn
  initial begin
    reset = 1'b1;
    power_off_n = 1'b1;
    // every input starts at a defined level; no pin is left floating
    general_inputs = 4'h0;
    id_lvl = 1'b0;
    err_count = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    HOST.idle(3);
    t_reset();
    t_frame();
    t_flash();
    t_gpi();
    t_power();
    test_done();
  end
endmodule : tb_top
